// [rtc_access_defs.svh]
// offsets, field positions, reset values and timing counts of the rtc access
`ifndef RTC_ACCESS_DEFS_SVH
`define RTC_ACCESS_DEFS_SVH

`define ADDR_FREEZE      3'h1
`define ADDR_CTRL        3'h7
`define CTRL_ALARM_EN    3
`define CTRL_CLKSEL_HI   7
`define CTRL_CLKSEL_LO   4
`define STAT_ALARM       7
`define STAT_CLKOUT      6
`define CTRL_RESET       8'h00
`define STAT_RESET       8'h00
`define SYNC_RESET       17'h03800
`define CLK_MHZ          40
`define FREEZE_WINDOW_MS 250
`define FREEZE_CYCLES    (`FREEZE_WINDOW_MS * 1000 * `CLK_MHZ)

`endif

// [rtc_access_pkg.sv]
// types shared by the rtc access logic
package rtc_access_pkg;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_MEM_RD = 2'b01,
		ST_MEM_WR = 2'b10,
		ST_IO_CYC = 2'b11
	} bus_state_t;
endpackage : rtc_access_pkg

// [pin_sync.sv]
// three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter int       W   = 1,
	parameter [W-1:0]   RST = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					s1[i] <= RST[i];
					s2[i] <= RST[i];
					s3[i] <= RST[i];
					q[i]  <= RST[i];
				end else begin
					s1[i] <= d[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						q[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule : pin_sync

// [clock_out_gen.sv]
// picks one of fifteen square waves and flags its falling edges
`timescale 1ns/100ps
module clock_out_gen (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [14:0] clock_taps,
	input  wire logic [3:0]  clk_sel,
	output logic             level,
	output logic             fall
);
	logic [14:0] taps;
	logic [3:0]  sel_prev;

	function automatic logic pick_tap(input logic [3:0] s,
		input logic [14:0] t);
		pick_tap = (s == 4'h0) ? 1'b1 : t[s - 4'h1];
	endfunction : pick_tap

	pin_sync #(.W(15), .RST(15'h0000)) u_tap_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.d       (clock_taps),
		.q       (taps)
	);

	wire next_level = pick_tap(clk_sel, taps);
	// a change of selection can look like an edge, so it is masked
	wire next_fall  = level && !next_level && (clk_sel != 4'h0)
		&& (clk_sel == sel_prev);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			level    <= 1'b1;
			fall     <= 1'b0;
			sel_prev <= 4'h0;
		end else begin
			level    <= next_level;
			fall     <= next_fall;
			sel_prev <= clk_sel;
		end
	end
endmodule : clock_out_gen

// [rtc_host_access.sv]
// host access, freeze and power-down logic of the bcd real-time clock
`timescale 1ns/100ps
`include "rtc_access_defs.svh"
module rtc_host_access #(
	parameter int FREEZE_CYCLES = `FREEZE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        mode_io,
	input  wire logic        chip_select,
	input  wire logic        select_latch_strobe,
	input  wire logic        write_timing_strobe,
	input  wire logic        read_strobe_b,
	input  wire logic [2:0]  register_select,
	input  wire logic [7:0]  data_lines_in,
	input  wire logic        power_down_b,
	input  wire logic        second_tick,
	input  wire logic        alarm_match,
	input  wire logic [14:0] clock_taps,
	input  wire logic [7:0]  counter_rd_data,
	output logic      [7:0]  data_lines_out,
	output logic             data_lines_oe,
	output logic      [2:0]  counter_addr,
	output logic      [7:0]  counter_wr_data,
	output logic             counter_wr,
	output logic             counter_tick,
	output logic      [7:0]  control_word,
	output logic             clock_out,
	output logic             int_out,
	output logic             int_oe
);
	////////////////////////////////////////////////////////////////////////
	// synchronised pins

	logic [16:0]               pins;
	rtc_access_pkg::bus_state_t state;
	rtc_access_pkg::bus_state_t next_state;
	logic        prev_tpa;
	logic        prev_wr;
	logic        cs_latched;
	logic [2:0]  io_addr;
	logic        pd_active;
	logic        pd_event;
	logic        tick_pending;
	logic [23:0] freeze_cnt;
	logic [7:0]  status;
	logic        prev_alarm;
	logic        clk_level;
	logic        clk_fall;

	pin_sync #(.W(17), .RST(`SYNC_RESET)) u_pin_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.d       ({mode_io, chip_select, select_latch_strobe,
			write_timing_strobe, read_strobe_b, power_down_b,
			register_select, data_lines_in}),
		.q       (pins)
	);

	wire       s_mode = pins[16];
	wire       s_cs   = pins[15];
	wire       s_tpa  = pins[14];
	wire       s_wr   = pins[13];
	wire       s_rd_b = pins[12];
	wire       s_pd_b = pins[11];
	wire [2:0] s_addr = pins[10:8];
	wire [7:0] s_data = pins[7:0];

	////////////////////////////////////////////////////////////////////////
	// bus cycle decoding

	wire tpa_fall = prev_tpa && !s_tpa;
	wire wr_rise  = !prev_wr && s_wr;
	wire wr_fall  = prev_wr && !s_wr;
	// a strobe held high leaves the select pin transparent
	wire sel_now  = s_tpa ? s_cs : cs_latched;
	wire [2:0] eff_addr = s_mode ? io_addr : s_addr;

	always_comb begin
		next_state = state;
		case (state)
			rtc_access_pkg::ST_IDLE: begin
				if (pd_active) begin
					next_state = rtc_access_pkg::ST_IDLE;
				end else if (s_mode) begin
					if (tpa_fall && cs_latched) begin
						next_state = rtc_access_pkg::ST_IO_CYC;
					end
				end else if (sel_now && !s_wr && s_rd_b) begin
					next_state = rtc_access_pkg::ST_MEM_WR;
				end else if (sel_now && !s_rd_b && s_wr) begin
					next_state = rtc_access_pkg::ST_MEM_RD;
				end
			end
			rtc_access_pkg::ST_MEM_WR: begin
				if (s_wr || !sel_now) begin
					next_state = rtc_access_pkg::ST_IDLE;
				end
			end
			rtc_access_pkg::ST_MEM_RD: begin
				if (s_rd_b || !sel_now) begin
					next_state = rtc_access_pkg::ST_IDLE;
				end
			end
			rtc_access_pkg::ST_IO_CYC: begin
				if (wr_fall) begin
					next_state = rtc_access_pkg::ST_IDLE;
				end
			end
			default: next_state = rtc_access_pkg::ST_IDLE;
		endcase
	end

	wire mem_write = (state == rtc_access_pkg::ST_MEM_WR) && wr_rise
		&& s_rd_b;
	wire io_write  = (state == rtc_access_pkg::ST_IO_CYC) && wr_fall
		&& !s_rd_b;
	wire do_write  = mem_write || io_write;
	wire ctrl_wr   = do_write && (eff_addr == `ADDR_CTRL);
	wire arm       = do_write && (eff_addr == `ADDR_FREEZE);
	wire next_oe   = (next_state == rtc_access_pkg::ST_MEM_RD)
		|| ((next_state == rtc_access_pkg::ST_IO_CYC) && s_rd_b);
	wire [7:0] rd_value = (eff_addr == `ADDR_CTRL) ? status
		: counter_rd_data;

	////////////////////////////////////////////////////////////////////////
	// freeze and power-down

	wire freeze_active = freeze_cnt != 24'h000000;
	wire hold = freeze_active || (state != rtc_access_pkg::ST_IDLE);
	wire tick_any = tick_pending || second_tick;
	// no entry while a cycle is open or about to open
	wire next_pd = !s_pd_b && (pd_active
		|| ((state == rtc_access_pkg::ST_IDLE)
		&& (next_state == rtc_access_pkg::ST_IDLE)));

	////////////////////////////////////////////////////////////////////////
	// interrupt sources and clock output

	wire [3:0] clk_sel  = control_word[`CTRL_CLKSEL_HI:`CTRL_CLKSEL_LO];
	wire ev_alarm = alarm_match && !prev_alarm
		&& control_word[`CTRL_ALARM_EN];
	wire ev_clk   = clk_fall;
	wire ev_any   = ev_alarm || ev_clk;
	// an event in the clearing cycle survives the clear
	wire [7:0] next_status = {ev_alarm || (status[`STAT_ALARM] && !ctrl_wr),
		ev_clk || (status[`STAT_CLKOUT] && !ctrl_wr), 6'h00};
	wire next_pd_event = next_pd && (pd_event || ev_any);
	wire next_clock = next_pd ? 1'b0 : clk_level;

	clock_out_gen u_clock_out_gen (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.clock_taps (clock_taps),
		.clk_sel    (clk_sel),
		.level      (clk_level),
		.fall       (clk_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state      <= rtc_access_pkg::ST_IDLE;
			prev_tpa   <= 1'b0;
			prev_wr    <= 1'b1;
			cs_latched <= 1'b0;
			io_addr    <= 3'h0;
			prev_alarm <= 1'b0;
		end else begin
			state      <= next_state;
			prev_tpa   <= s_tpa;
			prev_wr    <= s_wr;
			prev_alarm <= alarm_match;
			// follow while the strobe is high, hold from its fall: the pins
			// may already move on in the cycle in which the fall is seen
			if (s_tpa) begin
				cs_latched <= s_cs;
				if (s_mode) begin
					io_addr <= s_addr;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_lines_out  <= 8'h00;
			data_lines_oe   <= 1'b0;
			counter_addr    <= 3'h0;
			counter_wr_data <= 8'h00;
			counter_wr      <= 1'b0;
			control_word    <= `CTRL_RESET;
		end else begin
			data_lines_out  <= rd_value;
			data_lines_oe   <= next_oe;
			counter_addr    <= eff_addr;
			counter_wr_data <= s_data;
			counter_wr      <= do_write;
			if (ctrl_wr) begin
				control_word <= s_data;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			freeze_cnt   <= 24'h000000;
			tick_pending <= 1'b0;
			counter_tick <= 1'b0;
		end else begin
			// re-arming restarts the window, so it ends FREEZE_CYCLES after the last arm
			if (arm) begin
				freeze_cnt <= 24'(FREEZE_CYCLES);
			end else if (freeze_active) begin
				freeze_cnt <= freeze_cnt - 24'h000001;
			end
			tick_pending <= tick_any && hold;
			counter_tick <= tick_any && !hold;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status    <= `STAT_RESET;
			pd_active <= 1'b0;
			pd_event  <= 1'b0;
			clock_out <= 1'b1;
			int_out   <= 1'b1;
			int_oe    <= 1'b1;
		end else begin
			status    <= next_status;
			pd_active <= next_pd;
			pd_event  <= next_pd_event;
			clock_out <= next_clock;
			int_out   <= ~|next_status;
			int_oe    <= !next_pd || next_pd_event;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_tick_held;
		second_tick && hold;
	endsequence
	sequence s_io_read_open;
		(state == rtc_access_pkg::ST_IDLE) && !pd_active && s_mode
			&& tpa_fall && cs_latched && s_rd_b;
	endsequence

	a_tick_held_kept: assert property (
		s_tick_held |=> tick_pending)
		else $error("tick during access was dropped");
	a_tick_released: assert property (
		tick_pending && !hold |=> counter_tick && !tick_pending)
		else $error("held tick not applied after access");
	a_freeze_armed: assert property (
		arm |=> freeze_cnt == 24'(FREEZE_CYCLES))
		else $error("freeze not armed by address one write");
	a_mem_wr_rd_high: assert property (
		counter_wr && !$past(s_mode) |-> $past(s_rd_b))
		else $error("memory write taken with read strobe low");
	a_io_wr_rd_low: assert property (
		counter_wr && $past(s_mode) |-> !$past(s_rd_b))
		else $error("port write taken with read high");
	a_io_read_drive: assert property (
		s_io_read_open |=> data_lines_oe)
		else $error("port read not driven after select strobe");
	a_pd_bus_quiet: assert property (
		pd_active && $past(pd_active) |-> !counter_wr && !data_lines_oe)
		else $error("bus activity accepted in power-down");
	a_pd_after_cycle: assert property (
		$rose(pd_active) |-> $past(state) == rtc_access_pkg::ST_IDLE)
		else $error("power-down entered inside a bus cycle");
	a_pd_clock_low: assert property (
		pd_active |-> !clock_out)
		else $error("clock output not low in power-down");
	a_pd_int_float: assert property (
		$rose(pd_active) && !$past(ev_any) |-> !int_oe)
		else $error("interrupt still driven on power-down entry");
	a_clk_fall_int: assert property (
		ev_clk |=> status[`STAT_CLKOUT] && !int_out && int_oe)
		else $error("clock output edge did not raise interrupt");
	a_status_low_zero: assert property (
		data_lines_oe && counter_addr == `ADDR_CTRL
		|-> data_lines_out[5:0] == 6'h00)
		else $error("status low bits not zero");
endmodule : rtc_host_access

// [cpu_model.sv]
// processor-side pin model for memory and port mode accesses
`timescale 1ns/100ps
module cpu_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] data_lines_out,
	input  wire logic       data_lines_oe,
	output logic            mode_io,
	output logic            chip_select,
	output logic            select_latch_strobe,
	output logic            write_timing_strobe,
	output logic            read_strobe_b,
	output logic      [2:0] register_select,
	output wire logic [7:0] data_lines_in
);
	logic       drive = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] last  = 8'h00;
	// no keeper on the bus: a released bus shows a changing pattern
	assign data_lines_in = data_lines_oe ? data_lines_out
		: (drive ? wdata : ~last);
	always @(posedge clk_sys) last <= data_lines_in;
	initial begin
		mode_io = 1'b0;
		chip_select = 1'b0;
		select_latch_strobe = 1'b1;
		write_timing_strobe = 1'b1;
		read_strobe_b = 1'b1;
		register_select = 3'h0;
	end
	////////////////////////////////////////////////////////////////////////
	task set_mode(input logic m);
		@(negedge clk_sys);
		mode_io = m;
		select_latch_strobe = ~m;
		write_timing_strobe = ~m;
		repeat (8) @(negedge clk_sys);
	endtask : set_mode
	task mem_wr(input logic [2:0] a, input logic [7:0] d, input logic rd_b);
		@(negedge clk_sys);
		chip_select = 1'b1;
		register_select = a;
		wdata = d;
		drive = 1'b1;
		read_strobe_b = rd_b;
		write_timing_strobe = 1'b0;
		// strobe widths stay above the pin filter of the device
		repeat (5) @(negedge clk_sys);
		write_timing_strobe = 1'b1;
		repeat (7) @(negedge clk_sys);
		chip_select = 1'b0;
		drive = 1'b0;
		read_strobe_b = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask : mem_wr
	task mem_rd(input logic [2:0] a, output logic [7:0] q, input int hold);
		int n;
		@(negedge clk_sys);
		chip_select = 1'b1;
		register_select = a;
		read_strobe_b = 1'b0;
		for (n = 0; n < 20 && data_lines_oe !== 1'b1; n++) begin
			@(negedge clk_sys);
		end
		repeat (hold) @(negedge clk_sys);
		q = (data_lines_oe === 1'b1) ? data_lines_in : 8'hxx;
		read_strobe_b = 1'b1;
		chip_select = 1'b0;
		repeat (6) @(negedge clk_sys);
	endtask : mem_rd
	task io_cyc(input logic cs, input logic [2:0] a, input logic rd_b,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_sys);
		chip_select = cs;
		register_select = a;
		read_strobe_b = rd_b;
		select_latch_strobe = 1'b1;
		repeat (3) @(negedge clk_sys);
		select_latch_strobe = 1'b0;
		// port lines move on after the latch strobe, as a processor's do
		register_select = ~a;
		repeat (5) @(negedge clk_sys);
		wdata = d;
		drive = ~rd_b;
		write_timing_strobe = 1'b1;
		repeat (3) @(negedge clk_sys);
		q = (data_lines_oe === 1'b1) ? data_lines_in : 8'hxx;
		@(negedge clk_sys);
		write_timing_strobe = 1'b0;
		repeat (6) @(negedge clk_sys);
		drive = 1'b0;
		chip_select = 1'b0;
		read_strobe_b = 1'b1;
	endtask : io_cyc
endmodule : cpu_model

// [rtc_host_access_freeze_powerdown_tb_top.sv]
// self-checking bench for the rtc host access block
`timescale 1ns/100ps
module rtc_host_access_freeze_powerdown_tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        power_down_b = 1'b1;
	logic        second_tick = 1'b0;
	logic        alarm_match = 1'b0;
	logic        clk_prev = 1'b1;
	logic [19:0] tap_cnt = 20'h00000;
	logic [7:0]  data_lines_in, data_lines_out, counter_wr_data, control_word;
	logic [7:0]  counter_rd_data, last_data;
	logic [2:0]  register_select, counter_addr, last_addr;
	logic        mode_io, chip_select, select_latch_strobe, write_timing_strobe;
	logic        read_strobe_b, data_lines_oe, counter_wr, counter_tick;
	logic        clock_out, int_out, int_oe;
	logic [14:0] clock_taps;
	int          fails = 0, n_checks = 0, wr_cnt = 0, tick_cnt = 0, falls = 0;
	always #12.5 clk_sys = ~clk_sys;
	// slow taps keep every square wave well above the pin filter
	assign clock_taps = tap_cnt[19:5];
	assign counter_rd_data = {5'h14, counter_addr};
	always @(negedge clk_sys) tap_cnt <= tap_cnt + 20'h00001;
	always @(posedge clk_sys) begin
		clk_prev <= clock_out;
		if (counter_wr === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			last_addr <= counter_addr;
			last_data <= counter_wr_data;
		end
		if (counter_tick === 1'b1) tick_cnt <= tick_cnt + 1;
		if (clk_prev === 1'b1 && clock_out === 1'b0) falls <= falls + 1;
	end
	rtc_host_access #(.FREEZE_CYCLES(40)) u_rtc_host_access (
		.clk_sys, .rst_b, .mode_io, .chip_select, .select_latch_strobe,
		.write_timing_strobe, .read_strobe_b, .register_select, .data_lines_in,
		.power_down_b, .second_tick, .alarm_match, .clock_taps, .counter_rd_data,
		.data_lines_out, .data_lines_oe, .counter_addr, .counter_wr_data,
		.counter_wr, .counter_tick, .control_word, .clock_out, .int_out, .int_oe
	);
	cpu_model u_cpu_model (
		.clk_sys, .data_lines_out, .data_lines_oe, .mode_io, .chip_select,
		.select_latch_strobe, .write_timing_strobe, .read_strobe_b,
		.register_select, .data_lines_in
	);
	////////////////////////////////////////////////////////////////////////
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit
	task pulse_tick;
		second_tick = 1'b1;
		@(negedge clk_sys);
		second_tick = 1'b0;
	endtask : pulse_tick
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	task scn_memory;
		logic [7:0] q;
		int w0;
		w0 = wr_cnt;
		u_cpu_model.mem_wr(3'h7, 8'h08, 1'b1);
		chk_byte(8'(wr_cnt - w0), 8'h01);
		chk_byte({5'h00, last_addr}, 8'h07);
		chk_byte(last_data, 8'h08);
		chk_byte(control_word, 8'h08);
		u_cpu_model.mem_wr(3'h5, 8'h59, 1'b0);
		chk_byte(8'(wr_cnt - w0), 8'h01);
		u_cpu_model.mem_rd(3'h2, q, 1);
		chk_byte(q, 8'ha2);
		chk_bit(data_lines_oe, 1'b0);
		u_cpu_model.mem_rd(3'h7, q, 1);
		chk_byte(q, 8'h00);
	endtask : scn_memory
	task scn_freeze(input logic io);
		logic [7:0] q;
		int t0;
		t0 = tick_cnt;
		pulse_tick();
		repeat (3) @(negedge clk_sys);
		chk_byte(8'(tick_cnt - t0), 8'h01);
		// arm, then tick at once; host work stays well inside the window
		if (io) u_cpu_model.io_cyc(1'b1, 3'h1, 1'b0, 8'h00, q);
		else u_cpu_model.mem_wr(3'h1, 8'h00, 1'b1);
		pulse_tick();
		repeat (4) @(negedge clk_sys);
		chk_byte(8'(tick_cnt - t0), 8'h01);
		repeat (50) @(negedge clk_sys);
		chk_byte(8'(tick_cnt - t0), 8'h02);
	endtask : scn_freeze
	task scn_port;
		logic [7:0] q;
		int w0;
		u_cpu_model.set_mode(1'b1);
		w0 = wr_cnt;
		u_cpu_model.io_cyc(1'b1, 3'h7, 1'b0, 8'h09, q);
		chk_byte(control_word, 8'h09);
		chk_byte({5'h00, last_addr}, 8'h07);
		u_cpu_model.io_cyc(1'b1, 3'h4, 1'b1, 8'h00, q);
		chk_byte(q, 8'ha4);
		chk_bit(data_lines_oe, 1'b0);
		u_cpu_model.io_cyc(1'b0, 3'h7, 1'b0, 8'h30, q);
		chk_byte(8'(wr_cnt - w0), 8'h01);
		chk_byte(control_word, 8'h09);
		scn_freeze(1'b1);
		u_cpu_model.set_mode(1'b0);
	endtask : scn_port
	task scn_power_down;
		logic [7:0] q;
		int w0;
		u_cpu_model.mem_wr(3'h7, 8'h08, 1'b1);
		fork
			u_cpu_model.mem_rd(3'h3, q, 14);
			begin
				repeat (8) @(negedge clk_sys);
				power_down_b = 1'b0;
				repeat (6) @(negedge clk_sys);
				chk_bit(data_lines_oe, 1'b1);
				chk_bit(clock_out, 1'b1);
			end
		join
		chk_byte(q, 8'ha3);
		repeat (8) @(negedge clk_sys);
		chk_bit(clock_out, 1'b0);
		chk_bit(int_oe, 1'b0);
		w0 = wr_cnt;
		u_cpu_model.mem_wr(3'h7, 8'h10, 1'b1);
		chk_byte(8'(wr_cnt - w0), 8'h00);
		alarm_match = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk_bit(int_out, 1'b0);
		chk_bit(int_oe, 1'b1);
		chk_bit(clock_out, 1'b0);
		power_down_b = 1'b1;
		alarm_match = 1'b0;
		repeat (8) @(negedge clk_sys);
		u_cpu_model.mem_rd(3'h7, q, 1);
		chk_byte(q, 8'h80);
	endtask : scn_power_down
	task scn_clock;
		logic [7:0] q;
		int f0;
		for (int s = 1; s <= 3; s++) begin
			u_cpu_model.mem_wr(3'h7, {4'(s), 4'h0}, 1'b1);
			f0 = falls;
			repeat (512) @(negedge clk_sys);
			chk_byte(8'(falls - f0), 8'(16 >> s));
		end
		chk_bit(int_out, 1'b0);
		u_cpu_model.mem_rd(3'h7, q, 1);
		chk_byte(q, 8'h40);
		rst_b = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk_bit(int_out, 1'b1);
		chk_byte(control_word, 8'h00);
		rst_b = 1'b1;
		f0 = falls;
		repeat (128) @(negedge clk_sys);
		chk_byte(8'(falls - f0), 8'h00);
		chk_bit(clock_out, 1'b1);
		u_cpu_model.mem_rd(3'h7, q, 1);
		chk_byte(q, 8'h00);
	endtask : scn_clock
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge clk_sys);
		chk_bit(int_out, 1'b1);
		chk_bit(clock_out, 1'b1);
		chk_bit(data_lines_oe, 1'b0);
		chk_byte(control_word, 8'h00);
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (6) @(negedge clk_sys);
		scn_memory();
		scn_port();
		scn_freeze(1'b0);
		scn_power_down();
		scn_clock();
		complete_run();
	end
	initial begin
		#(25 * 20000);
		fails++;
		complete_run();
	end
endmodule : rtc_host_access_freeze_powerdown_tb_top
